// *** shared/mebt_pkg.sv ***
// Purpose: Shared constants and types for the external bus cycle controller
// Assumes: One core clock; all cycle counts are in core clock periods
// Notes:   Control register layout and cycle-length bases live here
package mebt_pkg;
    localparam logic [7:0] BUS_CYCLE_CONTROL_ADDR  = 8'h9D;
    localparam logic [7:0] BUS_CYCLE_CONTROL_RESET = 8'hEB;
    localparam int         QUEUE_EN_BIT  = 7;
    localparam int         CACHE_EN_BIT  = 6;
    localparam int         WR_WAIT_LSB   = 4;
    localparam int         RD_WAIT_LSB   = 2;
    localparam int         CODE_WAIT_LSB = 0;
    localparam logic [2:0] CODE_BASE   = 3'h3;
    localparam logic [2:0] DATA_BASE   = 3'h4;
    localparam logic [2:0] CONST_MIN   = 3'h4;

    typedef enum logic [1:0] {
        KIND_FETCH = 2'b00,
        KIND_CONST = 2'b01,
        KIND_READ  = 2'b10,
        KIND_WRITE = 2'b11
    } mebt_kind_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_XFER = 2'b10
    } mebt_state_t;

    typedef struct packed {
        mebt_kind_t  kind;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mebt_req_t;
endpackage : mebt_pkg

// *** verilog/mebt_bus_ctrl.sv ***
// Purpose: External multiplexed address/data bus cycle controller with its control register
// Assumes: Requests and stall/abort come from core logic on i_clk; AD inputs come from pins
// Notes:   All pin outputs are registered; AD output enables are active low
`timescale 1ns/10ps
module mebt_bus_ctrl (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic [7:0]        i_sfr_addr,
    input  wire logic [7:0]        i_sfr_wdata,
    input  wire logic              i_sfr_wr,
    input  wire logic              i_sfr_rd,
    output logic [7:0]             o_sfr_rdata,
    input  wire logic              i_req_valid,
    input  wire mebt_pkg::mebt_req_t i_req,
    output logic                   o_req_ready,
    input  wire logic              i_queue_stall,
    input  wire logic              i_fetch_abort,
    output logic                   o_done,
    output logic [15:0]            o_rdata,
    output logic                   o_prefetch_queue_enable,
    output logic                   o_branch_cache_enable,
    input  wire logic [15:0]       i_ad,
    output logic [15:0]            o_ad,
    output logic                   o_ad_lo_oe_n,
    output logic                   o_ad_hi_oe_n,
    output logic                   o_ale,
    output logic                   o_code_fetch_strobe_n,
    output logic                   o_rd_n,
    output logic                   o_wr_n,
    input  wire logic [7:0]        i_portb_addr_sel,
    input  wire logic [7:0]        i_portb_func,
    output logic [7:0]             o_portb
);
    // Cycle length from the control fields; fixed per kind, never per address
    function automatic logic [2:0] cyc_len(input mebt_pkg::mebt_kind_t k, input logic [7:0] c);
        logic [1:0] cwt;
        cwt = c[mebt_pkg::CODE_WAIT_LSB +: 2];
        case (k)
            mebt_pkg::KIND_FETCH: cyc_len = mebt_pkg::CODE_BASE + {1'b0, cwt};
            mebt_pkg::KIND_CONST: cyc_len = (cwt == 2'b00) ? mebt_pkg::CONST_MIN
                                            : mebt_pkg::CODE_BASE + {1'b0, cwt};
            mebt_pkg::KIND_READ:  cyc_len = mebt_pkg::DATA_BASE
                                            + {1'b0, c[mebt_pkg::RD_WAIT_LSB +: 2]};
            default:              cyc_len = mebt_pkg::DATA_BASE
                                            + {1'b0, c[mebt_pkg::WR_WAIT_LSB +: 2]};
        endcase
    endfunction : cyc_len

    logic [15:0] ad_meta_q, ad_sync_q;
    logic [7:0]  ctrl_q, ctrl_d, sfr_rdata_q, sfr_rdata_d, portb_q, portb_d;
    mebt_pkg::mebt_state_t state_q, state_d;
    mebt_pkg::mebt_req_t   req_q, req_d;
    logic [2:0]  cnt_q, cnt_d, len_q, len_d;
    logic [15:0] ad_q, ad_d, rdata_q, rdata_d;
    logic        lo_oe_n_q, lo_oe_n_d, hi_oe_n_q, hi_oe_n_d;
    logic        ale_q, ale_d, fstb_n_q, fstb_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;
    logic        done_q, done_d, ready_q, ready_d;
    logic        is_code, last;

    // Pin inputs pass two flops; only the second is read
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ad_meta_q <= 16'h0000;
            ad_sync_q <= 16'h0000;
        end else begin
            ad_meta_q <= i_ad;
            ad_sync_q <= ad_meta_q;
        end
    end

    assign is_code = (req_q.kind == mebt_pkg::KIND_FETCH) || (req_q.kind == mebt_pkg::KIND_CONST);
    assign last    = (cnt_q == len_q - 3'h1);

    always_comb begin
        ctrl_d      = ctrl_q;
        sfr_rdata_d = 8'h00;
        if (i_sfr_wr && (i_sfr_addr == mebt_pkg::BUS_CYCLE_CONTROL_ADDR)) begin
            ctrl_d = i_sfr_wdata;
        end
        if (i_sfr_rd && (i_sfr_addr == mebt_pkg::BUS_CYCLE_CONTROL_ADDR)) begin
            sfr_rdata_d = ctrl_q;
        end
        // Address bits are selected per pin; the rest keep their other function
        for (int i = 0; i < 8; i++) begin
            portb_d[i] = i_portb_addr_sel[i] ? req_q.addr[8+i] : i_portb_func[i];
        end
    end

    always_comb begin
        state_d   = state_q;
        req_d     = req_q;
        cnt_d     = cnt_q;
        len_d     = len_q;
        ad_d      = ad_q;
        lo_oe_n_d = lo_oe_n_q;
        hi_oe_n_d = hi_oe_n_q;
        ale_d     = 1'b0;
        fstb_n_d  = fstb_n_q;
        rd_n_d    = rd_n_q;
        wr_n_d    = wr_n_q;
        rdata_d   = rdata_q;
        done_d    = 1'b0;
        ready_d   = ready_q;
        case (state_q)
            mebt_pkg::PH_IDLE: begin
                if (i_req_valid) begin
                    // Length is frozen at start so a register write mid-cycle is harmless
                    req_d     = i_req;
                    len_d     = cyc_len(i_req.kind, ctrl_q);
                    cnt_d     = 3'h0;
                    state_d   = mebt_pkg::PH_ADDR;
                    ale_d     = 1'b1;
                    ad_d      = i_req.addr;
                    lo_oe_n_d = 1'b0;
                    hi_oe_n_d = 1'b0;
                    ready_d   = 1'b0;
                end
            end
            mebt_pkg::PH_ADDR: begin
                state_d = mebt_pkg::PH_XFER;
                cnt_d   = 3'h1;
                if (is_code) begin
                    fstb_n_d  = 1'b0;
                    lo_oe_n_d = 1'b1;
                    hi_oe_n_d = 1'b1;
                end else if (req_q.kind == mebt_pkg::KIND_READ) begin
                    rd_n_d    = 1'b0;
                    lo_oe_n_d = 1'b1;
                end else begin
                    wr_n_d        = 1'b0;
                    ad_d[7:0]     = req_q.wdata;
                end
            end
            default: begin
                if ((req_q.kind == mebt_pkg::KIND_FETCH) && i_fetch_abort) begin
                    state_d = mebt_pkg::PH_IDLE;
                end else if (last && !(req_q.kind == mebt_pkg::KIND_FETCH && i_queue_stall)) begin
                    // Stall only holds fetches; data reads end on count alone
                    state_d = mebt_pkg::PH_IDLE;
                    done_d  = 1'b1;
                    if (is_code) begin
                        rdata_d = ad_sync_q;
                    end else begin
                        rdata_d = {8'h00, ad_sync_q[7:0]};
                    end
                end else if (!last) begin
                    cnt_d = cnt_q + 3'h1;
                end
                if (state_d == mebt_pkg::PH_IDLE) begin
                    fstb_n_d  = 1'b1;
                    rd_n_d    = 1'b1;
                    wr_n_d    = 1'b1;
                    lo_oe_n_d = 1'b1;
                    hi_oe_n_d = 1'b1;
                    ready_d   = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q      <= mebt_pkg::BUS_CYCLE_CONTROL_RESET;
            sfr_rdata_q <= 8'h00;
            portb_q     <= 8'h00;
            state_q     <= mebt_pkg::PH_IDLE;
            req_q       <= '0;
            cnt_q       <= 3'h0;
            len_q       <= 3'h0;
            ad_q        <= 16'h0000;
            lo_oe_n_q   <= 1'b1;
            hi_oe_n_q   <= 1'b1;
            ale_q       <= 1'b0;
            fstb_n_q    <= 1'b1;
            rd_n_q      <= 1'b1;
            wr_n_q      <= 1'b1;
            rdata_q     <= 16'h0000;
            done_q      <= 1'b0;
            ready_q     <= 1'b1;
        end else begin
            ctrl_q      <= ctrl_d;
            sfr_rdata_q <= sfr_rdata_d;
            portb_q     <= portb_d;
            state_q     <= state_d;
            req_q       <= req_d;
            cnt_q       <= cnt_d;
            len_q       <= len_d;
            ad_q        <= ad_d;
            lo_oe_n_q   <= lo_oe_n_d;
            hi_oe_n_q   <= hi_oe_n_d;
            ale_q       <= ale_d;
            fstb_n_q    <= fstb_n_d;
            rd_n_q      <= rd_n_d;
            wr_n_q      <= wr_n_d;
            rdata_q     <= rdata_d;
            done_q      <= done_d;
            ready_q     <= ready_d;
        end
    end

    assign o_sfr_rdata             = sfr_rdata_q;
    assign o_req_ready             = ready_q;
    assign o_done                  = done_q;
    assign o_rdata                 = rdata_q;
    assign o_prefetch_queue_enable = ctrl_q[mebt_pkg::QUEUE_EN_BIT];
    assign o_branch_cache_enable   = ctrl_q[mebt_pkg::CACHE_EN_BIT];
    assign o_ad                    = ad_q;
    assign o_ad_lo_oe_n            = lo_oe_n_q;
    assign o_ad_hi_oe_n            = hi_oe_n_q;
    assign o_ale                   = ale_q;
    assign o_code_fetch_strobe_n   = fstb_n_q;
    assign o_rd_n                  = rd_n_q;
    assign o_wr_n                  = wr_n_q;
    assign o_portb                 = portb_q;

    // Helper: cycles spent in the current bus cycle, for length checks
    logic [3:0] act_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            act_q <= 4'h0;
        end else begin
            act_q <= (state_q == mebt_pkg::PH_IDLE) ? 4'h0 : act_q + 4'h1;
        end
    end

    AST_SFR_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_sfr_wr && i_sfr_addr == mebt_pkg::BUS_CYCLE_CONTROL_ADDR
        |=> o_prefetch_queue_enable == $past(i_sfr_wdata[7]) && ctrl_q == $past(i_sfr_wdata))
        else $error("control register write not taken");
    AST_WRITE_LOW_BYTE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !o_wr_n |-> !o_ad_lo_oe_n && o_ad[7:0] == req_q.wdata)
        else $error("write data not on low byte");
    AST_READ_LEN: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == mebt_pkg::PH_IDLE && i_req_valid && i_req.kind == mebt_pkg::KIND_READ
        |=> len_q == 3'h4 + {1'b0, $past(ctrl_q[3:2])})
        else $error("read length wrong");
    AST_WRITE_LEN: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == mebt_pkg::PH_IDLE && i_req_valid && i_req.kind == mebt_pkg::KIND_WRITE
        |=> len_q == 3'h4 + {1'b0, $past(ctrl_q[5:4])})
        else $error("write length wrong");
    AST_CONST_MIN: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == mebt_pkg::PH_IDLE && i_req_valid && i_req.kind == mebt_pkg::KIND_CONST
        && ctrl_q[1:0] == 2'b00 |=> len_q == 3'h4)
        else $error("constant read shorter than four");
    AST_READ_EXACT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_rd_n) |-> $past(act_q) + 4'h1 == {1'b0, len_q})
        else $error("data read length not exact");
    AST_STALL_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == mebt_pkg::PH_XFER && req_q.kind == mebt_pkg::KIND_FETCH && last
        && i_queue_stall && !i_fetch_abort |=> !o_code_fetch_strobe_n && !o_done)
        else $error("fetch ended during stall");
    AST_ABORT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == mebt_pkg::PH_XFER && req_q.kind == mebt_pkg::KIND_FETCH && i_fetch_abort
        |=> o_code_fetch_strobe_n && !o_done && o_req_ready)
        else $error("fetch abort ignored");
    AST_PORTB_SEL: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_portb_addr_sel[0] |=> o_portb[0] == $past(req_q.addr[8]))
        else $error("port B address pin wrong");
    AST_ALE_PULSE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_ale |-> o_ad_lo_oe_n == 1'b0 ##1 !o_ale)
        else $error("address strobe not one cycle");

    COV_READ:  cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_rd_n));
    COV_WRITE: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_wr_n));
    COV_STALL: cover property (@(posedge i_clk) disable iff (!i_resetn)
        !o_code_fetch_strobe_n && i_queue_stall && last);
    COV_ABORT: cover property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == mebt_pkg::PH_XFER && req_q.kind == mebt_pkg::KIND_FETCH && i_fetch_abort);
endmodule : mebt_bus_ctrl

// *** bench/mebt_ext_mem.sv ***
// Purpose: Byte-wide external memory with an address latch, seen from the AD pins
// Assumes: Low address byte is captured from AD while the latch strobe is high
// Notes:   Undriven AD bytes show the inverse of their last value, so stale data never matches
`timescale 1ns/10ps
module mebt_ext_mem (
    input  wire logic        i_clk,
    input  wire logic        i_ale,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_code_fetch_strobe_n,
    input  wire logic        i_ad_lo_oe_n,
    input  wire logic        i_ad_hi_oe_n,
    input  wire logic [15:0] i_ad,
    output logic      [15:0] o_ad
);
    logic [7:0]  mem [0:255];
    logic [7:0]  lat_q;
    logic [15:0] last_q;
    logic [15:0] drv;
    always_ff @(posedge i_clk) begin
        if (i_ale) lat_q <= i_ad[7:0];
        if (!i_wr_n) mem[lat_q] <= i_ad[7:0];
        last_q <= o_ad;
    end
    always_comb begin
        drv = ~last_q;
        if (!i_code_fetch_strobe_n) drv = {~lat_q, lat_q};
        else if (!i_rd_n) drv[7:0] = mem[lat_q];
    end
    // Wire level: whoever has its enable on wins the byte
    assign o_ad = {i_ad_hi_oe_n ? drv[15:8] : i_ad[15:8], i_ad_lo_oe_n ? drv[7:0] : i_ad[7:0]};
endmodule : mebt_ext_mem

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for the external bus cycle controller
// Assumes: Requests start only while the controller is idle
// Notes:   Cycle length is counted in edges from the taking edge to the done pulse
`timescale 1ns/10ps
module testbench;
    logic                i_clk = 0, i_resetn = 0, sfr_wr = 0, sfr_rd = 0, req_valid = 0;
    logic [7:0]          sfr_addr = 0, sfr_wdata = 0, sfr_rdata, portb_sel = 0, portb_func = 0;
    logic [7:0]          portb, d;
    mebt_pkg::mebt_req_t req = '0;
    logic                req_ready, queue_stall = 0, fetch_abort = 0, done, queue_en, cache_en;
    logic                lo_oe_n, hi_oe_n, ale, cfs_n, rd_n, wr_n;
    logic [15:0]         rdata, ad_in, ad_out;
    logic [1:0]          c;
    int                  n_mismatch = 0, comparisons = 0, cycles = 0, n;
    always #2.5 i_clk = ~i_clk;
    mebt_bus_ctrl mebt_bus_ctrl_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_sfr_addr(sfr_addr),
        .i_sfr_wdata(sfr_wdata), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .o_sfr_rdata(sfr_rdata),
        .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
        .i_queue_stall(queue_stall), .i_fetch_abort(fetch_abort), .o_done(done), .o_rdata(rdata),
        .o_prefetch_queue_enable(queue_en), .o_branch_cache_enable(cache_en), .i_ad(ad_in),
        .o_ad(ad_out), .o_ad_lo_oe_n(lo_oe_n), .o_ad_hi_oe_n(hi_oe_n), .o_ale(ale),
        .o_code_fetch_strobe_n(cfs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .i_portb_addr_sel(portb_sel), .i_portb_func(portb_func), .o_portb(portb));
    mebt_ext_mem mebt_ext_mem_i (.i_clk(i_clk), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_code_fetch_strobe_n(cfs_n), .i_ad_lo_oe_n(lo_oe_n), .i_ad_hi_oe_n(hi_oe_n),
        .i_ad(ad_out), .o_ad(ad_in));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1;
        @(posedge i_clk);
        #1 sfr_wr = 0;
    endtask : sfr_write
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
        sfr_addr = a;
        sfr_rd = 1;
        @(posedge i_clk);
        #1 sfr_rd = 0;
        // Read data stands for one cycle only, right after the taking edge
        v = sfr_rdata;
    endtask : sfr_read
    // Returns edges from the taking edge to done; 40 means no done was seen
    task automatic bus(input mebt_pkg::mebt_kind_t k, input logic [15:0] a,
                       input logic [7:0] w, output int cnt);
        check("ready before request", 16'h0001, {15'h0000, req_ready});
        req.kind = k;
        req.addr = a;
        req.wdata = w;
        req_valid = 1;
        @(posedge i_clk);
        #1 req_valid = 0;
        cnt = 0;
        do begin
            @(posedge i_clk);
            #1 cnt++;
        end while (done !== 1'b1 && cnt < 40);
    endtask : bus
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    always @(posedge i_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial begin
        repeat (8) @(posedge i_clk);
        #1 i_resetn = 1;
        sfr_read(mebt_pkg::BUS_CYCLE_CONTROL_ADDR, d);
        check("ctrl after reset", 16'h00EB, {8'h00, d});
        check("enables after reset", 16'h0003, {14'h0000, queue_en, cache_en});
        bus(mebt_pkg::KIND_READ, 16'h0010, 8'h00, n);
        check("read length reset", 16'h0006, n[15:0]);
        bus(mebt_pkg::KIND_WRITE, 16'h0011, 8'h00, n);
        check("write length reset", 16'h0006, n[15:0]);
        bus(mebt_pkg::KIND_FETCH, 16'h0012, 8'h00, n);
        check("fetch length reset", 16'h0006, n[15:0]);
        $display("test reset defaults done");
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            sfr_write(mebt_pkg::BUS_CYCLE_CONTROL_ADDR, {2'b00, c, c, c});
            check("enables cleared", 16'h0000, {14'h0000, queue_en, cache_en});
            bus(mebt_pkg::KIND_FETCH, 16'h0020, 8'h00, n);
            check("fetch length", 16'(i + 3), n[15:0]);
            bus(mebt_pkg::KIND_CONST, 16'h8020, 8'h00, n);
            check("const length", 16'((i == 0) ? 4 : i + 3), n[15:0]);
            bus(mebt_pkg::KIND_READ, 16'hF030, 8'h00, n);
            check("read length", 16'(i + 4), n[15:0]);
            bus(mebt_pkg::KIND_WRITE, 16'h0031, 8'h00, n);
            check("write length", 16'(i + 4), n[15:0]);
        end
        $display("test wait codes done");
        portb_sel = 8'h07;
        portb_func = 8'hA0;
        bus(mebt_pkg::KIND_WRITE, 16'h1240, 8'h3C, n);
        bus(mebt_pkg::KIND_READ, 16'h1240, 8'h00, n);
        check("byte read data", 16'h003C, rdata);
        check("port b mix", 16'h00A2, {8'h00, portb});
        bus(mebt_pkg::KIND_FETCH, 16'h0055, 8'h00, n);
        check("fetch word", 16'hAA55, rdata);
        $display("test data paths done");
        sfr_write(8'h9C, 8'hFF);
        sfr_read(mebt_pkg::BUS_CYCLE_CONTROL_ADDR, d);
        check("ctrl kept", 16'h003F, {8'h00, d});
        sfr_read(8'h9C, d);
        check("unmapped read", 16'h0000, {8'h00, d});
        // Five periods for every cycle type, as firmware sets them for a fast clock
        sfr_write(mebt_pkg::BUS_CYCLE_CONTROL_ADDR, 8'hD6);
        bus(mebt_pkg::KIND_READ, 16'h0050, 8'h00, n);
        check("read five", 16'h0005, n[15:0]);
        bus(mebt_pkg::KIND_FETCH, 16'h0051, 8'h00, n);
        check("fetch five", 16'h0005, n[15:0]);
        // Slow clock setting: three for fetches, four for data and constant reads
        sfr_write(mebt_pkg::BUS_CYCLE_CONTROL_ADDR, 8'hC0);
        bus(mebt_pkg::KIND_FETCH, 16'h0052, 8'h00, n);
        check("fetch three", 16'h0003, n[15:0]);
        bus(mebt_pkg::KIND_WRITE, 16'h0053, 8'h00, n);
        check("write four", 16'h0004, n[15:0]);
        sfr_write(mebt_pkg::BUS_CYCLE_CONTROL_ADDR, mebt_pkg::BUS_CYCLE_CONTROL_RESET);
        check("enables set", 16'h0003, {14'h0000, queue_en, cache_en});
        $display("test register map done");
        queue_stall = 1;
        bus(mebt_pkg::KIND_READ, 16'h0040, 8'h00, n);
        check("read ignores stall", 16'h0006, n[15:0]);
        fork
            bus(mebt_pkg::KIND_FETCH, 16'h0041, 8'h00, n);
            begin
                repeat (9) @(posedge i_clk);
                #1 queue_stall = 0;
            end
        join
        check("fetch stretched", 16'h0001, {15'h0000, n > 7 && n < 12});
        fetch_abort = 1;
        bus(mebt_pkg::KIND_READ, 16'h0042, 8'h00, n);
        check("read ignores abort", 16'h0006, n[15:0]);
        bus(mebt_pkg::KIND_FETCH, 16'h0043, 8'h00, n);
        check("aborted fetch no done", 16'h0028, n[15:0]);
        check("ready after abort", 16'h0001, {15'h0000, req_ready});
        fetch_abort = 0;
        $display("test stall and abort done");
        report_and_stop;
    end
endmodule : testbench
